// [verilog/iqp_consts.vh]
// Purpose: constants for the i/q output correction and protection block
// Assumes: 8-bit register addresses and data
// Notes:   definitions only
`ifndef IQP_CONSTS_VH
`define IQP_CONSTS_VH
`define IQP_A_THR_LO   8'h29
`define IQP_A_THR_HI   8'h2A
`define IQP_A_WIN      8'h2B
`define IQP_A_CFG27    8'h27
`define IQP_A_PH_HI    8'h37
`define IQP_A_PH_LO    8'h38
`define IQP_A_IOFF_LO  8'h3B
`define IQP_A_IOFF_HI  8'h3C
`define IQP_A_QOFF_LO  8'h3D
`define IQP_A_QOFF_HI  8'h3E
`define IQP_A_IGAIN    8'h3F
`define IQP_A_QGAIN    8'h40
`define IQP_A_UP       8'h41
`define IQP_A_DN       8'h42
`define IQP_A_TXACT    8'h43
`define IQP_A_CTRL     8'h44
`define IQP_A_STAT     8'h45
`define IQP_A_AVG_LO   8'h46
`define IQP_A_AVG_HI   8'h47
`define IQP_B_DROOP    7
`define IQP_B_GAIN_EN  0
`define IQP_B_PH_EN    1
`define IQP_B_PROT_EN  2
`define IQP_B_MUTE     3
`define IQP_GAIN_RST   6'h20
`define IQP_STEP_RST   6'h01
`define IQP_UNITY      6'h20
`define IQP_PROT_DLY   4
`define IQP_WIN_MAX    3'h4
`endif

// [verilog/iqp_pow_ram.v]
// Purpose: sample power history for the moving average
// Assumes: one write and one read each clock
// Notes:   read returns old contents on an address clash
`timescale 1ns/10ps
module iqp_pow_ram (
  input  wire        core_clk,
  input  wire [3:0]  wr_addr,
  input  wire [11:0] wr_data,
  input  wire [3:0]  rd_addr,
  output reg  [11:0] rd_data
);
  reg [11:0] mem [0:15];

  // no reset: contents are masked by the fill count
  always @(posedge core_clk) begin
    mem[wr_addr] <= wr_data;
    rd_data      <= mem[rd_addr];
  end
endmodule

// [verilog/iqp_core.v]
// Purpose: i/q gain, phase, droop filter, dc offset, power guard, tx gate
// Assumes: one i/q sample per core_clk; signed 16-bit samples
// Notes:   stage latency depends on enables; keep them fixed in service
//
// Chosen here: strobed register access.
`timescale 1ns/10ps
`include "iqp_consts.vh"
module iqp_core (
  input  wire        core_clk,
  input  wire        reset,
  input  wire [7:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [7:0]  reg_rdata,
  input  wire        transmit_gate_pin,
  input  wire [15:0] data_i,
  input  wire [15:0] data_q,
  output reg  [15:0] dac_i,
  output reg  [15:0] dac_q,
  output reg         dac_sleep,
  output reg         dac_power_down
);
  localparam ST_RUN   = 2'b00;
  localparam ST_DOWN  = 2'b01;
  localparam ST_SLEEP = 2'b10;
  localparam ST_PD    = 2'b11;

  // saturate a wide signed value to 16 bits
  function [15:0] sat16;
    input signed [39:0] v;
    begin
      if (v > 40'sh0000007FFF)
        sat16 = 16'h7FFF;
      else if (v < -40'sh0000008000)
        sat16 = 16'h8000;
      else
        sat16 = v[15:0];
    end
  endfunction

  // window field to log2 of length, capped at 16 samples
  function [2:0] win_log;
    input [3:0] f;
    begin
      if (f > {1'b0, `IQP_WIN_MAX})
        win_log = `IQP_WIN_MAX;
      else
        win_log = f[2:0];
    end
  endfunction

  reg [7:0] thr_lo_q, thr_hi_q, win_q, ph_hi_q, ph_lo_q;
  reg [7:0] ioff_lo_q, ioff_hi_q, qoff_lo_q, qoff_hi_q;
  reg [7:0] igain_q, qgain_q, up_q, dn_q, cfg27_q, txact_q, ctrl_q;
  reg [7:0] rd_d;
  reg       over_q;
  reg [15:0] sum_q;
  reg [1:0] st_q;
  reg [5:0] ramp_q;
  reg       tx_q;

  wire gain_en  = ctrl_q[`IQP_B_GAIN_EN];
  wire ph_en    = ctrl_q[`IQP_B_PH_EN];
  wire prot_en  = ctrl_q[`IQP_B_PROT_EN];
  wire mute_sel = ctrl_q[`IQP_B_MUTE];
  wire droop_filter_on = cfg27_q[`IQP_B_DROOP];
  wire [2:0]  wl  = win_log(win_q[3:0]);
  wire [15:0] avg = sum_q >> wl;

  // register writes; only documented field bits are kept
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      thr_lo_q  <= 8'h00;
      thr_hi_q  <= 8'h00;
      win_q     <= 8'h00;
      ph_hi_q   <= 8'h00;
      ph_lo_q   <= 8'h00;
      ioff_lo_q <= 8'h00;
      ioff_hi_q <= 8'h00;
      qoff_lo_q <= 8'h00;
      qoff_hi_q <= 8'h00;
      igain_q   <= {2'b00, `IQP_GAIN_RST};
      qgain_q   <= {2'b00, `IQP_GAIN_RST};
      up_q      <= {2'b00, `IQP_STEP_RST};
      dn_q      <= {2'b00, `IQP_STEP_RST};
      cfg27_q   <= 8'h00;
      txact_q   <= 8'h00;
      ctrl_q    <= 8'h00;
    end else if (reg_wr) begin
      case (reg_addr)
        `IQP_A_THR_LO:  thr_lo_q  <= reg_wdata;
        `IQP_A_THR_HI:  thr_hi_q  <= {3'b000, reg_wdata[4:0]};
        `IQP_A_WIN:     win_q     <= {4'h0, reg_wdata[3:0]};
        `IQP_A_CFG27:   cfg27_q   <= {reg_wdata[7], 7'h00};
        `IQP_A_PH_HI:   ph_hi_q   <= reg_wdata;
        `IQP_A_PH_LO:   ph_lo_q   <= {3'b000, reg_wdata[4:0]};
        `IQP_A_IOFF_LO: ioff_lo_q <= reg_wdata;
        `IQP_A_IOFF_HI: ioff_hi_q <= reg_wdata;
        `IQP_A_QOFF_LO: qoff_lo_q <= reg_wdata;
        `IQP_A_QOFF_HI: qoff_hi_q <= reg_wdata;
        `IQP_A_IGAIN:   igain_q   <= {2'b00, reg_wdata[5:0]};
        `IQP_A_QGAIN:   qgain_q   <= {2'b00, reg_wdata[5:0]};
        `IQP_A_UP:      up_q      <= {2'b00, reg_wdata[5:0]};
        `IQP_A_DN:      dn_q      <= {2'b00, reg_wdata[5:0]};
        `IQP_A_TXACT:   txact_q   <= {6'h00, reg_wdata[1:0]};
        `IQP_A_CTRL:    ctrl_q    <= {4'h0, reg_wdata[3:0]};
        default:        ctrl_q    <= ctrl_q;
      endcase
    end
  end

  // read mux; unmapped addresses read zero
  always @* begin
    case (reg_addr)
      `IQP_A_THR_LO:  rd_d = thr_lo_q;
      `IQP_A_THR_HI:  rd_d = thr_hi_q;
      `IQP_A_WIN:     rd_d = win_q;
      `IQP_A_CFG27:   rd_d = cfg27_q;
      `IQP_A_PH_HI:   rd_d = ph_hi_q;
      `IQP_A_PH_LO:   rd_d = ph_lo_q;
      `IQP_A_IOFF_LO: rd_d = ioff_lo_q;
      `IQP_A_IOFF_HI: rd_d = ioff_hi_q;
      `IQP_A_QOFF_LO: rd_d = qoff_lo_q;
      `IQP_A_QOFF_HI: rd_d = qoff_hi_q;
      `IQP_A_IGAIN:   rd_d = igain_q;
      `IQP_A_QGAIN:   rd_d = qgain_q;
      `IQP_A_UP:      rd_d = up_q;
      `IQP_A_DN:      rd_d = dn_q;
      `IQP_A_TXACT:   rd_d = txact_q;
      `IQP_A_CTRL:    rd_d = ctrl_q;
      `IQP_A_STAT:    rd_d = {2'b00, st_q, ramp_q == `IQP_UNITY, tx_q, 1'b0, over_q};
      `IQP_A_AVG_LO:  rd_d = avg[7:0];
      `IQP_A_AVG_HI:  rd_d = avg[15:8];
      default:        rd_d = 8'h00;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always @(posedge core_clk or posedge reset) begin
    if (reset)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= rd_d;
    else
      reg_rdata <= 8'h00;
  end

  // gain stage, registered only when enabled
  wire signed [15:0] in_i = data_i;
  wire signed [15:0] in_q = data_q;
  wire signed [22:0] gi_p = in_i * $signed({1'b0, igain_q[5:0]});
  wire signed [22:0] gq_p = in_q * $signed({1'b0, qgain_q[5:0]});
  wire signed [39:0] gi_w = gi_p >>> 5;
  wire signed [39:0] gq_w = gq_p >>> 5;
  reg  signed [15:0] g_i_q, g_q_q;
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      g_i_q <= 16'h0000;
      g_q_q <= 16'h0000;
    end else begin
      g_i_q <= sat16(gi_w);
      g_q_q <= sat16(gq_w);
    end
  end
  wire signed [15:0] a_i = gain_en ? g_i_q : in_i;
  wire signed [15:0] a_q = gain_en ? g_q_q : in_q;

  // phase stage: q picks up a signed fraction of i
  wire signed [12:0] ph_code = {ph_hi_q, ph_lo_q[4:0]};
  wire signed [28:0] ph_p = a_i * ph_code;
  wire signed [39:0] ph_w = a_q + (ph_p >>> 14);
  reg  signed [15:0] p_i_q, p_q_q;
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      p_i_q <= 16'h0000;
      p_q_q <= 16'h0000;
    end else begin
      p_i_q <= a_i;
      p_q_q <= sat16(ph_w);
    end
  end
  wire signed [15:0] b_i = ph_en ? p_i_q : a_i;
  wire signed [15:0] b_q = ph_en ? p_q_q : a_q;

  // droop filter per path; taps run always so enabling is glitch free
  wire [31:0] b_iq = {b_q, b_i};
  wire [31:0] c_iq;
  genvar p;
  generate
    for (p = 0; p < 2; p = p + 1) begin : g_droop
      reg  [111:0] sh;
      reg  [15:0]  y;
      wire signed [25:0] e0 = $signed(sh[15:0]);
      wire signed [25:0] e1 = $signed(sh[31:16]);
      wire signed [25:0] e2 = $signed(sh[47:32]);
      wire signed [25:0] e3 = $signed(sh[63:48]);
      wire signed [25:0] e4 = $signed(sh[79:64]);
      wire signed [25:0] e5 = $signed(sh[95:80]);
      wire signed [25:0] e6 = $signed(sh[111:96]);
      // coefficients sum to 166 over 256: the built-in loss
      wire signed [25:0] s = (e3 <<< 7) + (e3 <<< 6) - ((e2 + e4) <<< 4)
                             + ((e1 + e5) <<< 2) - e0 - e6;
      wire signed [39:0] sw = s >>> 8;
      always @(posedge core_clk or posedge reset) begin
        if (reset) begin
          sh <= 112'h0;
          y  <= 16'h0000;
        end else begin
          sh <= {sh[95:0], b_iq[16*p+15:16*p]};
          y  <= sat16(sw);
        end
      end
      assign c_iq[16*p+15:16*p] = droop_filter_on ? y : b_iq[16*p+15:16*p];
    end
  endgenerate

  // dc offset stage, never bypassed, one register always
  wire signed [39:0] oi_w = $signed(c_iq[15:0]) + $signed({ioff_hi_q, ioff_lo_q});
  wire signed [39:0] oq_w = $signed(c_iq[31:16]) + $signed({qoff_hi_q, qoff_lo_q});
  reg  [15:0] d_i_q, d_q_q;
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      d_i_q <= 16'h0000;
      d_q_q <= 16'h0000;
    end else begin
      d_i_q <= sat16(oi_w);
      d_q_q <= sat16(oq_w);
    end
  end

  // extra delay lets the detector lead the data when guarding
  reg [32*`IQP_PROT_DLY-1:0] dly_q;
  always @(posedge core_clk or posedge reset) begin
    if (reset)
      dly_q <= {32*`IQP_PROT_DLY{1'b0}};
    else
      dly_q <= {dly_q[32*`IQP_PROT_DLY-33:0], d_q_q, d_i_q};
  end
  wire [31:0] dl_iq = dly_q[32*`IQP_PROT_DLY-1:32*`IQP_PROT_DLY-32];
  wire signed [15:0] f_i = prot_en ? dl_iq[15:0] : d_i_q;
  wire signed [15:0] f_q = prot_en ? dl_iq[31:16] : d_q_q;

  // power of top six bits, registered
  wire signed [5:0]  hi_i = data_i[15:10];
  wire signed [5:0]  hi_q = data_q[15:10];
  wire signed [11:0] sqi = hi_i * hi_i;
  wire signed [11:0] sqq = hi_q * hi_q;
  reg  [11:0] pw_q, pw_d1_q;
  reg  [3:0]  wp_q;
  reg  [4:0]  fill_q;
  reg         old_ok_q;
  reg  [2:0]  wl_q;
  wire [11:0] old_pw;
  wire [4:0]  wlen = 5'h01 << wl;
  wire        wchg = wl != wl_q;

  iqp_pow_ram u_ram (
    .core_clk (core_clk),
    .wr_addr  (wp_q),
    .wr_data  (pw_q),
    .rd_addr  (wp_q - wlen[3:0]),
    .rd_data  (old_pw)
  );

  // running sum over the window; restart on a window change
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pw_q     <= 12'h000;
      pw_d1_q  <= 12'h000;
      wp_q     <= 4'h0;
      fill_q   <= 5'h00;
      old_ok_q <= 1'b0;
      wl_q     <= 3'h0;
      sum_q    <= 16'h0000;
    end else begin
      pw_q    <= $unsigned(sqi) + $unsigned(sqq);
      pw_d1_q <= pw_q;
      wp_q    <= wp_q + 4'h1;
      wl_q    <= wl;
      if (wchg) begin
        fill_q   <= 5'h01; // next edge adds the sample taken now
        old_ok_q <= 1'b0;
        sum_q    <= 16'h0000;
      end else begin
        if (fill_q < 5'h10)
          fill_q <= fill_q + 5'h01;
        old_ok_q <= fill_q >= wlen;
        sum_q <= sum_q + {4'h0, pw_d1_q} - (old_ok_q ? {4'h0, old_pw} : 16'h0000);
      end
    end
  end

  // threshold compare, only while the guard is enabled
  always @(posedge core_clk or posedge reset) begin
    if (reset)
      over_q <= 1'b0;
    else
      over_q <= prot_en && (avg > {3'b000, thr_hi_q[4:0], thr_lo_q});
  end

  // transmit gate pin: three flops, change taken when last two agree
  reg s1_q, s2_q, s3_q;
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      s1_q <= 1'b1; // idle at transmit, so no false fall
      s2_q <= 1'b1;
      s3_q <= 1'b1;
      tx_q <= 1'b1;
    end else begin
      s1_q <= transmit_gate_pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q)
        tx_q <= s3_q;
    end
  end

  // gate state and output gain ramp
  wire [6:0] up_sum = {1'b0, ramp_q} + {1'b0, up_q[5:0]};
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      st_q   <= ST_RUN;
      ramp_q <= `IQP_UNITY;
    end else begin
      case (st_q)
        ST_RUN: begin
          if (!tx_q) begin
            case (txact_q[1:0])
              2'b00:   st_q <= ST_DOWN;
              2'b01:   st_q <= ST_SLEEP;
              default: st_q <= ST_PD;
            endcase
          end else if (up_sum > {1'b0, `IQP_UNITY})
            ramp_q <= `IQP_UNITY;
          else
            ramp_q <= up_sum[5:0];
        end
        ST_DOWN: begin
          if (tx_q)
            st_q <= ST_RUN;
          else if (ramp_q > dn_q[5:0])
            ramp_q <= ramp_q - dn_q[5:0];
          else
            ramp_q <= 6'h00;
        end
        ST_SLEEP, ST_PD: begin
          ramp_q <= 6'h00; // restart from zero on wake
          if (tx_q)
            st_q <= ST_RUN;
        end
        default: st_q <= ST_RUN;
      endcase
    end
  end

  // guard and ramp at the very end, just before the converter
  wire signed [15:0] m_i = over_q ? (mute_sel ? 16'sh0000 : f_i >>> 2) : f_i;
  wire signed [15:0] m_q = over_q ? (mute_sel ? 16'sh0000 : f_q >>> 2) : f_q;
  wire signed [22:0] ri_p = m_i * $signed({1'b0, ramp_q});
  wire signed [22:0] rq_p = m_q * $signed({1'b0, ramp_q});
  wire signed [39:0] ri_w = ri_p >>> 5;
  wire signed [39:0] rq_w = rq_p >>> 5;
  wire off = (st_q == ST_SLEEP) || (st_q == ST_PD);
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      dac_i          <= 16'h0000;
      dac_q          <= 16'h0000;
      dac_sleep      <= 1'b0;
      dac_power_down <= 1'b0;
    end else begin
      dac_i          <= off ? 16'h0000 : sat16(ri_w);
      dac_q          <= off ? 16'h0000 : sat16(rq_w);
      dac_sleep      <= st_q == ST_SLEEP;
      dac_power_down <= st_q == ST_PD;
    end
  end
endmodule

// [verification/iqp_core_sva.sv]
// Purpose: port-level checks for iqp_core
// Assumes: single clock, async active-high reset
// Notes:   attached by the bind at the foot
`timescale 1ns/10ps
module iqp_core_sva (
  input wire        core_clk,
  input wire        reset,
  input wire [7:0]  reg_addr,
  input wire [7:0]  reg_wdata,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [7:0]  reg_rdata,
  input wire        transmit_gate_pin,
  input wire [15:0] dac_i,
  input wire [15:0] dac_q,
  input wire        dac_sleep,
  input wire        dac_power_down
);
  reg [7:0] wd_q;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);
  // last written byte, so a readback can be judged
  always @(posedge core_clk or posedge reset) begin
    if (reset)
      wd_q <= 8'h00;
    else if (reg_wr)
      wd_q <= reg_wdata;
  end
  chk_gain_readback:
    assert property (reg_wr && reg_addr == 8'h3F ##1 reg_rd && reg_addr == 8'h3F
      |=> reg_rdata == {2'b00, wd_q[5:0]}) else $error("gain readback wrong");
  chk_rdata_idle:
    assert property (!reg_rd |=> reg_rdata == 8'h00) else $error("read data not idle");
  chk_unmapped_zero:
    assert property (reg_rd && reg_addr < 8'h27 |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
  chk_sleep_quiet:
    assert property (dac_sleep ##1 dac_sleep |-> dac_i == 16'h0000 && dac_q == 16'h0000)
      else $error("output live in sleep");
  chk_down_quiet:
    assert property (dac_power_down ##1 dac_power_down |-> dac_i == 16'h0000 && dac_q == 16'h0000)
      else $error("output live in power down");
  chk_one_state:
    assert property (!(dac_sleep && dac_power_down)) else $error("sleep and power down");
  chk_gate_high_run:
    assert property (transmit_gate_pin [*8] |-> !dac_sleep && !dac_power_down)
      else $error("not running with gate high");
  chk_sleep_cause:
    assert property ($rose(dac_sleep) |-> !$past(transmit_gate_pin))
      else $error("sleep without gate low");
  chk_down_cause:
    assert property ($rose(dac_power_down) |-> !$past(transmit_gate_pin))
      else $error("power down without gate low");
endmodule
bind iqp_core iqp_core_sva chk (
  .core_clk          (core_clk),
  .reset             (reset),
  .reg_addr          (reg_addr),
  .reg_wdata         (reg_wdata),
  .reg_wr            (reg_wr),
  .reg_rd            (reg_rd),
  .reg_rdata         (reg_rdata),
  .transmit_gate_pin (transmit_gate_pin),
  .dac_i             (dac_i),
  .dac_q             (dac_q),
  .dac_sleep         (dac_sleep),
  .dac_power_down    (dac_power_down)
);

// [verification/iqp_src_model.sv]
// Purpose: upstream datapath stand-in feeding one i/q pair per clock
// Assumes: bench chooses the sample pair
// Notes:   registered like a real pipeline stage, so no same-edge race
`timescale 1ns/10ps
module iqp_src_model (
  input  wire        core_clk,
  input  wire        reset,
  input  wire [15:0] want_i,
  input  wire [15:0] want_q,
  output reg  [15:0] data_i,
  output reg  [15:0] data_q
);
  // zero stream in reset, then the requested pair every clock
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      data_i <= 16'h0000;
      data_q <= 16'h0000;
    end else begin
      data_i <= want_i;
      data_q <= want_q;
    end
  end
endmodule

// [verification/testbench.sv]
// Purpose: self-checking bench for iqp_core
// Assumes: stimulus by nonblocking assignment at rising edges
// Notes:   notes queued by drivers, matched by one watcher process
`timescale 1ns/10ps
module testbench;
  reg         core_clk;
  reg         reset;
  reg  [7:0]  reg_addr;
  reg  [7:0]  reg_wdata;
  reg         reg_wr;
  reg         reg_rd;
  reg         transmit_gate_pin;
  reg  [15:0] want_i;
  reg  [15:0] want_q;
  wire [7:0]  reg_rdata;
  wire [15:0] data_i;
  wire [15:0] data_q;
  wire [15:0] dac_i;
  wire [15:0] dac_q;
  wire        dac_sleep;
  wire        dac_power_down;
  integer     bad_count;
  integer     n_compared;
  integer     k;
  reg         rd_seen;
  reg  [15:0] rnd;
  reg  [12:0] pc;
  reg  [7:0]  rd_exp[$];
  reg  [31:0] smp_exp[$];
  longint     xi, xq, oi, oq, gi, gq, cs;

  iqp_src_model src (.core_clk(core_clk), .reset(reset), .want_i(want_i),
    .want_q(want_q), .data_i(data_i), .data_q(data_q));
  iqp_core uut (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .transmit_gate_pin(transmit_gate_pin), .data_i(data_i), .data_q(data_q),
    .dac_i(dac_i), .dac_q(dac_q), .dac_sleep(dac_sleep), .dac_power_down(dac_power_down));

  // 100 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  function [15:0] lfsr(input [15:0] x);
    lfsr = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  function [15:0] sat(input longint v);
    sat = v > 32767 ? 16'h7FFF : v < -32768 ? 16'h8000 : v[15:0];
  endfunction

  task end_of_test;
    if (bad_count == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task cmp(input string nm, input [31:0] e, input [31:0] s);
    n_compared = n_compared + 1;
    if (e !== s) begin
      bad_count = bad_count + 1;
      $display("wrong value %s exp %h got %h", nm, e, s);
    end
  endtask

  // bus tasks leave the strobe up; run(), gate() or a bus task of the other kind drops it
  task wr(input [7:0] a, input [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    reg_addr <= a;
    reg_wdata <= d;
  endtask

  task rd(input [7:0] a, input [7:0] e);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_wr <= 1'b0;
    reg_addr <= a;
    rd_exp.push_back(e);
  endtask

  // new sample pair, then wait n cycles to let the pipeline flush
  task run(input [15:0] i, input [15:0] q, input integer n);
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    want_i <= i;
    want_q <= q;
    repeat (n) @(posedge core_clk);
  endtask

  task chk(input [15:0] ei, input [15:0] eq);
    @(posedge core_clk);
    #1 smp_exp.push_back({ei, eq});
  endtask

  // drive the gate pin and wait, bounded, for the matching status
  task gate(input v, input [1:0] st);
    integer n;
    @(posedge core_clk);
    transmit_gate_pin <= v;
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    n = 0;
    @(posedge core_clk);
    while ({dac_power_down, dac_sleep} !== st && n < 20) begin
      @(posedge core_clk);
      n = n + 1;
    end
    if (n == 20) begin
      bad_count = bad_count + 1;
      $display("wrong value gate status exp %h got %h", st, {dac_power_down, dac_sleep});
      end_of_test;
    end
  endtask

  // watcher: read data one cycle after the strobe, samples when noted
  always @(posedge core_clk) begin
    rd_seen <= reg_rd;
    if (rd_seen && rd_exp.size() > 0)
      cmp("reg_rdata", {24'h0, rd_exp.pop_front()}, {24'h0, reg_rdata});
    if (smp_exp.size() > 0)
      cmp("dac_i_q", smp_exp.pop_front(), {dac_i, dac_q});
  end

  initial begin
    reset = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    transmit_gate_pin = 1'b1;
    want_i = 16'h0000;
    want_q = 16'h0000;
    bad_count = 0;
    n_compared = 0;
    rd_seen = 1'b0;
    rnd = 16'hE60F;
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    // defaults, unmapped place, field widths
    rd(8'h3F, 8'h20);
    rd(8'h40, 8'h20);
    rd(8'h3C, 8'h00);
    rd(8'h27, 8'h00);
    wr(8'h10, 8'hA5);
    rd(8'h10, 8'h00);
    wr(8'h27, 8'hFF);
    rd(8'h27, 8'h80);
    wr(8'h3F, 8'hFF);
    rd(8'h3F, 8'h3F);
    wr(8'h27, 8'h00);
    // random offsets and gains, gain stage on every other pass
    for (k = 0; k < 6; k = k + 1) begin
      rnd = lfsr(rnd);
      xi = $signed(rnd);
      rnd = lfsr(rnd);
      xq = $signed(rnd);
      rnd = lfsr(rnd);
      oi = $signed(rnd);
      oq = $signed({rnd[7:0], rnd[15:8]});
      gi = k[0] ? rnd[5:0] : 32;
      gq = k[0] ? rnd[11:6] : 32;
      wr(8'h3B, rnd[7:0]);
      wr(8'h3C, rnd[15:8]);
      wr(8'h3D, rnd[15:8]);
      wr(8'h3E, rnd[7:0]);
      wr(8'h3F, {2'b00, rnd[5:0]});
      wr(8'h40, {2'b00, rnd[11:6]});
      wr(8'h44, {7'h00, k[0]});
      run(xi[15:0], xq[15:0], 16);
      chk(sat($signed(sat((xi * gi) >>> 5)) + oi), sat($signed(sat((xq * gq) >>> 5)) + oq));
    end
    for (k = 0; k < 4; k = k + 1)
      wr(8'h3B + k[7:0], 8'h00);
    // phase code at both extremes
    wr(8'h44, 8'h02);
    for (k = 0; k < 2; k = k + 1) begin
      pc = k[0] ? 13'h1000 : 13'h0FFF;
      cs = $signed(pc);
      wr(8'h37, pc[12:5]);
      wr(8'h38, {3'b000, pc[4:0]});
      run(16'h4000, 16'h1000, 16);
      chk(16'h4000, sat(4096 + ((16384 * cs) >>> 14)));
    end
    // droop filter on a flat input
    wr(8'h44, 8'h00);
    wr(8'h27, 8'h80);
    run(16'h1000, 16'hF000, 16);
    chk(sat((4096 * 166) >>> 8), sat((-4096 * 166) >>> 8));
    wr(8'h27, 8'h00);
    // power guard: mute, then attenuate, then a high threshold
    wr(8'h29, 8'h01);
    wr(8'h2A, 8'h00);
    wr(8'h2B, 8'h00);
    wr(8'h44, 8'h0C);
    run(16'h03FF, 16'h03FF, 16);
    chk(16'h03FF, 16'h03FF);
    run(16'h7000, 16'h7000, 16);
    chk(16'h0000, 16'h0000);
    wr(8'h44, 8'h04);
    run(16'h7000, 16'h7000, 16);
    chk(16'h1C00, 16'h1C00);
    wr(8'h29, 8'hFF);
    wr(8'h2A, 8'h1F);
    wr(8'h2B, 8'h02);
    run(16'h7000, 16'h7000, 16);
    chk(16'h7000, 16'h7000);
    rd(8'h46, 8'h20);
    rd(8'h47, 8'h06);
    // gate actions: sleep and power down, each with a slow ramp back
    wr(8'h44, 8'h00);
    run(16'h2000, 16'h2000, 4);
    for (k = 1; k < 3; k = k + 1) begin
      wr(8'h43, k[7:0]);
      gate(1'b0, k[1:0]);
      chk(16'h0000, 16'h0000);
      rd(8'h45, k[0] ? 8'h20 : 8'h30);
      gate(1'b1, 2'b00);
      run(16'h2000, 16'h2000, 40);
      chk(16'h2000, 16'h2000);
    end
    // ramp down with a big step, ramp up with step 8
    wr(8'h42, 8'h3F);
    wr(8'h43, 8'h00);
    wr(8'h41, 8'h08);
    gate(1'b0, 2'b00);
    run(16'h2000, 16'h2000, 10);
    chk(16'h0000, 16'h0000);
    gate(1'b1, 2'b00);
    run(16'h2000, 16'h2000, 10);
    chk(16'h2000, 16'h2000);
    run(16'h2000, 16'h2000, 4);
    end_of_test;
  end
endmodule
